// file: radio_packet_transfer_framer_tb.sv
// Self-checking bench for the radio packet framer
`timescale 1ns/1ps
module radio_packet_transfer_framer_tb;
  logic mclk = 0, rst = 1, ce = 1, hostRd = 0, rxPreambleSeen = 0, modReady, txUnderrun, irq;
  rpf_pkg::rpf_ctrl_t ctrl = '0;
  rpf_pkg::rpf_byte_t hostWr = '0, rxSym = '0, hostRdData, txSym;
  rpf_pkg::rpf_stat_t stat;
  logic [6:0] hostAddr = '0;
  logic [7:0] energy = 8'h80;
  logic [3:0] channelSel;
  logic [7:0] rdq[$];
  int mismatches = 0, check_count = 0, irqs = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (irq === 1'b1) irqs++;
    if (hostRdData.valid === 1'b1) rdq.push_back(hostRdData.data);
  end
  rpf_framer uut (.mclk(mclk), .rst(rst), .ce(ce), .ctrl(ctrl), .hostWr(hostWr),
    .hostAddr(hostAddr), .hostRd(hostRd), .hostRdData(hostRdData), .rxSym(rxSym),
    .rxPreambleSeen(rxPreambleSeen), .energy(energy), .modReady(modReady), .txSym(txSym),
    .stat(stat), .channelSel(channelSel), .txUnderrun(txUnderrun), .irq(irq));
  rpf_mod_model #(.GAP(2)) modm (.mclk(mclk), .rst(rst), .txSym(txSym), .modReady(modReady));
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waited(input logic done);
    if (done !== 1'b1) begin
      mismatches++;
      $display("Error wait expected done seen timeout");
      test_done();
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [15:0] crc(input logic [7:0] p[$]);
    logic [15:0] c;
    c = rpf_pkg::FCS_INIT;
    foreach (p[i]) begin
      c ^= {8'h00, p[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ rpf_pkg::FCS_POLY_REV : c >> 1;
    end
    return c;
  endfunction
  task automatic ramrd(input logic [6:0] a, input logic [7:0] exp);
    rdq.delete();
    hostAddr = a;
    hostRd = 1;
    tick(1);
    hostRd = 0;
    tick(3);
    chk("ram read", {8'h00, exp}, (rdq.size() == 1) ? {8'h00, rdq[0]} : 16'hFFFF);
  endtask
  task automatic test_chan();
    for (int c = 0; c < 16; c += 5) begin
      ctrl.channel = 4'(c);
      tick(2);
      chk("channel", 16'(c), {12'h000, channelSel});
    end
    ce = 0;
    ctrl.channel = 4'h3;
    tick(3);
    chk("frozen channel", 16'h000F, {12'h000, channelSel});
    ce = 1;
    tick(2);
    chk("channel", 16'h0003, {12'h000, channelSel});
  endtask
  task automatic test_tx();
    logic [7:0] pl[$] = '{8'h11, 8'h22, 8'h33};
    logic [7:0] ex[$];
    logic [15:0] f;
    int n0;
    f = crc(pl);
    ex = {8'h00, 8'h00, 8'h00, 8'h00, rpf_pkg::SFD_BYTE, 8'h03, pl, f[7:0], f[15:8]};
    foreach (pl[i]) begin
      hostAddr = 7'(i);
      hostWr = '{1'b1, pl[i]};
      tick(1);
    end
    hostWr = '0;
    ramrd(7'h01, 8'h22);
    n0 = irqs;
    ctrl.txLen = 8'h03;
    ctrl.txStart = 1;
    tick(1);
    ctrl.txStart = 0;
    for (int i = 0; i < 400 && modm.got.size() < ex.size(); i++) tick(1);
    waited(modm.got.size() == ex.size());
    foreach (ex[i]) chk("tx byte", {8'h00, ex[i]}, {8'h00, modm.got[i]});
    tick(4);
    chk("tx done irq", 16'(n0 + 1), 16'(irqs));
  endtask
  task automatic test_rx(input bit good, input bit strm);
    logic [7:0] pl[$] = '{8'h5A, 8'hC3, 8'h0F, 8'hF0};
    logic [7:0] by[$];
    logic [15:0] f;
    int n0;
    f = crc(pl) ^ (good ? 16'h0000 : 16'h0100);
    by = {rpf_pkg::SFD_BYTE, 8'h04, pl, f[7:0], f[15:8]};
    ctrl.streamMode = strm;
    ctrl.rxEnable = 1;
    rdq.delete();
    n0 = irqs;
    rxPreambleSeen = 1;
    tick(1);
    rxPreambleSeen = 0;
    foreach (by[i]) begin
      rxSym = '{1'b1, by[i]};
      tick(1);
      rxSym = '{1'b0, ~by[i]};
      tick(1);
    end
    tick(3);
    ctrl.rxEnable = 0;
    chk("rx length", 16'h0004, {8'h00, stat.rxLen});
    chk("crc result", 16'(good), {15'h0000, stat.crcOk});
    if (strm) begin
      chk("stream irqs", 16'(n0 + 4), 16'(irqs));
      chk("stream count", 16'h0004, 16'(rdq.size()));
      foreach (rdq[i]) chk("stream byte", {8'h00, pl[i]}, {8'h00, rdq[i]});
    end else begin
      chk("rx irq", 16'(n0 + 1), 16'(irqs));
      foreach (by[i]) if (i >= 2) ramrd(7'(i - 2), by[i]);
      if (good) begin
        tick(3300);
        ramrd(rpf_pkg::LQI_ADDR, 8'h64);
      end
    end
  endtask
  task automatic test_stx(input bit late);
    logic [7:0] pl[$] = '{8'hA1, 8'hB2, 8'hC3};
    logic [7:0] ex[$];
    logic [15:0] f;
    int n0, i;
    ctrl.streamMode = 1;
    modm.got.delete();
    n0 = irqs;
    ctrl.txLen = 8'h03;
    ctrl.txStart = 1;
    tick(1);
    ctrl.txStart = 0;
    foreach (pl[k]) begin
      for (i = 0; i < 60 && irq !== 1'b1; i++) tick(1);
      waited(irq);
      if (late && k == pl.size() - 1) begin
        // Withheld word: the framer sends the idle host data instead
        pl[k] = 8'h00;
      end else begin
        hostWr = '{1'b1, pl[k]};
        for (i = 0; i < 60 && txSym.valid !== 1'b1; i++) tick(1);
        waited(txSym.valid);
        hostWr = '0;
      end
    end
    f = crc(pl);
    ex = {8'h00, 8'h00, 8'h00, 8'h00, rpf_pkg::SFD_BYTE, 8'h03, pl, f[7:0], f[15:8]};
    for (i = 0; i < 100 && modm.got.size() < ex.size(); i++) tick(1);
    waited(modm.got.size() == ex.size());
    foreach (ex[j]) chk("stream tx byte", {8'h00, ex[j]}, {8'h00, modm.got[j]});
    tick(4);
    chk("stream tx irqs", 16'(n0 + 3), 16'(irqs));
    chk("underrun", 16'(late), {15'h0000, txUnderrun});
  endtask
  task automatic test_cca();
    int i;
    ctrl.ccaStart = 1;
    tick(1);
    ctrl.ccaStart = 0;
    for (i = 0; i < 7000 && stat.ccaDone !== 1'b1; i++) tick(1);
    waited(stat.ccaDone);
    chk("cca window", 16'h0001, 16'(i >= 6398));
    chk("cca level", 16'h0064, {8'h00, stat.ccaLevel});
  endtask
  initial begin
    tick(8);
    rst = 0;
    tick(2);
    test_chan();
    test_tx();
    test_rx(1, 0);
    test_rx(0, 0);
    test_rx(1, 1);
    test_stx(0);
    test_stx(1);
    test_cca();
    test_done();
  end
endmodule

// file: rpf_framer.sv
// Packet framer: transmit framing, receive parsing, check sequence, link quality, clear channel
`timescale 1ns/1ps
module rpf_framer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire rpf_pkg::rpf_ctrl_t ctrl,
  input wire rpf_pkg::rpf_byte_t hostWr,
  input wire logic [6:0] hostAddr,
  input wire logic hostRd,
  output rpf_pkg::rpf_byte_t hostRdData,
  input wire rpf_pkg::rpf_byte_t rxSym,
  input wire logic rxPreambleSeen,
  input wire logic [7:0] energy,
  input wire logic modReady,
  output rpf_pkg::rpf_byte_t txSym,
  output rpf_pkg::rpf_stat_t stat,
  output logic [3:0] channelSel,
  output logic txUnderrun,
  output logic irq
);
  typedef enum {TX_IDLE, TX_PRE, TX_SFD, TX_LEN, TX_PAY, TX_FCS0, TX_FCS1} rpf_txst_t;
  typedef enum {RX_IDLE, RX_SFD, RX_LEN, RX_PAY, RX_FCS0, RX_FCS1} rpf_rxst_t;

  function automatic logic [15:0] fcsStep(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ rpf_pkg::FCS_POLY_REV;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  rpf_txst_t txState;
  rpf_rxst_t rxState;
  logic [7:0] txCnt;
  logic [7:0] txLen;
  logic [15:0] txCrc;
  logic txWait;
  logic [7:0] rxCnt;
  logic [7:0] rxLen;
  logic [15:0] rxCrc;
  logic [7:0] rxFcsLo;
  logic [12:0] lqCnt;
  logic lqActive;
  logic [19:0] lqAcc;
  logic lqStore;
  logic [12:0] ccaCnt;
  logic ccaBusy;
  logic [20:0] ccaAcc;
  logic [7:0] ramRdData;
  logic rdPending;
  logic crcOk;
  logic [7:0] rxLenDone;
  logic [7:0] ccaLevel;
  logic ccaDone;

  // Stream transmit word delivered by host
  wire streamTx = ctrl.streamMode;
  wire txFire = modReady && txState != TX_IDLE && !txWait;
  wire [7:0] txPayByte = streamTx ? hostWr.data : ramRdData;
  wire [15:0] txCrcNext = fcsStep(txCrc, txPayByte);
  wire [15:0] rxCrcNext = fcsStep(rxCrc, rxSym.data);
  wire [15:0] rxFcsRx = {rxSym.data, rxFcsLo};
  wire rxPayWr = rxSym.valid && rxState == RX_PAY;
  wire rxFcsWr = rxSym.valid && (rxState == RX_FCS0 || rxState == RX_FCS1);
  wire hostRamWr = hostWr.valid && !streamTx && txState == TX_IDLE;
  wire ramWe = rxPayWr || rxFcsWr || lqStore || hostRamWr;
  wire [6:0] rxAddr = rxCnt[6:0];
  wire [6:0] ramWrAddr = lqStore ? rpf_pkg::LQI_ADDR : (hostRamWr ? hostAddr : rxAddr);
  wire [7:0] ramWrData = lqStore ? lqAcc[19:12] : (hostRamWr ? hostWr.data : rxSym.data);
  wire [6:0] ramRdAddr = (txState != TX_IDLE) ? txCnt[6:0] : hostAddr;
  wire [7:0] ctrlLen = (ctrl.txLen > rpf_pkg::MAX_PAYLOAD_B) ? rpf_pkg::MAX_PAYLOAD_B : ctrl.txLen;
  // Level taken with the last sample of the window included
  wire [20:0] ccaAccNext = ccaAcc + {13'h0000, energy};
  assign stat = '{crcOk: crcOk, rxLen: rxLenDone, ccaLevel: ccaLevel, ccaDone: ccaDone};

  rpf_ram uRam (
    .mclk(mclk),
    .ce(ce),
    .we(ramWe),
    .wrAddr(ramWrAddr),
    .wrData(ramWrData),
    .rdAddr(ramRdAddr),
    .rdData(ramRdData)
  );

  // Transmit framer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txState <= TX_IDLE;
      txCnt <= 8'h00;
      txLen <= 8'h00;
      txCrc <= 16'h0000;
      txWait <= 1'b0;
      txSym <= '0;
      txUnderrun <= 1'b0;
    end else if (ce) begin
      txSym.valid <= 1'b0;
      txWait <= 1'b0;
      case (txState)
        TX_IDLE: begin
          if (ctrl.txStart) begin
            txState <= TX_PRE;
            txCnt <= 8'h00;
            txLen <= ctrlLen;
            txCrc <= rpf_pkg::FCS_INIT;
            txUnderrun <= 1'b0;
          end
        end
        TX_PRE: begin
          if (txFire) begin
            txSym <= '{valid: 1'b1, data: rpf_pkg::PREAMBLE_BYTE};
            if (txCnt == 8'(rpf_pkg::PREAMBLE_LEN - 1)) begin
              txState <= TX_SFD;
            end else begin
              txCnt <= txCnt + 8'h01;
            end
          end
        end
        TX_SFD: begin
          if (txFire) begin
            txSym <= '{valid: 1'b1, data: rpf_pkg::SFD_BYTE};
            txState <= TX_LEN;
          end
        end
        TX_LEN: begin
          if (txFire) begin
            txSym <= '{valid: 1'b1, data: txLen};
            txCnt <= 8'h00;
            txWait <= 1'b1;
            txState <= (txLen == 8'h00) ? TX_FCS0 : TX_PAY;
          end
        end
        TX_PAY: begin
          if (txFire) begin
            if (streamTx && !hostWr.valid) begin
              txUnderrun <= 1'b1;
            end
            txSym <= '{valid: 1'b1, data: txPayByte};
            txCrc <= txCrcNext;
            txCnt <= txCnt + 8'h01;
            txWait <= 1'b1;
            if (txCnt + 8'h01 == txLen) begin
              txState <= TX_FCS0;
            end
          end
        end
        TX_FCS0: begin
          if (txFire) begin
            txSym <= '{valid: 1'b1, data: txCrc[7:0]};
            txState <= TX_FCS1;
          end
        end
        TX_FCS1: begin
          if (txFire) begin
            txSym <= '{valid: 1'b1, data: txCrc[15:8]};
            txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // Receive parser
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxState <= RX_IDLE;
      rxCnt <= 8'h00;
      rxLen <= 8'h00;
      rxCrc <= 16'h0000;
      rxFcsLo <= 8'h00;
      crcOk <= 1'b0;
      rxLenDone <= 8'h00;
    end else if (ce) begin
      case (rxState)
        RX_IDLE: begin
          if (ctrl.rxEnable && rxPreambleSeen) begin
            rxState <= RX_SFD;
          end
        end
        RX_SFD: begin
          if (rxSym.valid) begin
            rxState <= (rxSym.data == rpf_pkg::SFD_BYTE) ? RX_LEN : RX_IDLE;
          end
        end
        RX_LEN: begin
          if (rxSym.valid) begin
            rxCnt <= 8'h00;
            rxCrc <= rpf_pkg::FCS_INIT;
            rxLen <= rxSym.data;
            if (rxSym.data > rpf_pkg::MAX_PAYLOAD_B) begin
              rxState <= RX_IDLE;
            end else begin
              rxState <= (rxSym.data == 8'h00) ? RX_FCS0 : RX_PAY;
            end
          end
        end
        RX_PAY: begin
          if (rxSym.valid) begin
            rxCrc <= rxCrcNext;
            rxCnt <= rxCnt + 8'h01;
            if (rxCnt + 8'h01 == rxLen) begin
              rxState <= RX_FCS0;
            end
          end
        end
        RX_FCS0: begin
          if (rxSym.valid) begin
            rxFcsLo <= rxSym.data;
            rxCnt <= rxCnt + 8'h01;
            rxState <= RX_FCS1;
          end
        end
        RX_FCS1: begin
          if (rxSym.valid) begin
            crcOk <= (rxFcsRx == rxCrc);
            rxLenDone <= rxLen;
            rxState <= RX_IDLE;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Link quality over the window after the preamble
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lqCnt <= 13'h0000;
      lqActive <= 1'b0;
      lqAcc <= 20'h00000;
      lqStore <= 1'b0;
    end else if (ce) begin
      lqStore <= 1'b0;
      if (!lqActive && rxState == RX_IDLE && ctrl.rxEnable && rxPreambleSeen) begin
        lqActive <= 1'b1;
        lqCnt <= 13'h0000;
        lqAcc <= 20'h00000;
      end else if (lqActive) begin
        lqAcc <= lqAcc + {12'h000, energy};
        lqCnt <= lqCnt + 13'h0001;
        if (lqCnt == 13'(rpf_pkg::LQ_CYCLES - 1)) begin
          lqActive <= 1'b0;
          lqStore <= 1'b1;
        end
      end
    end
  end

  // Clear channel assessment and channel select
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ccaCnt <= 13'h0000;
      ccaBusy <= 1'b0;
      ccaAcc <= 21'h000000;
      ccaLevel <= 8'h00;
      ccaDone <= 1'b0;
      channelSel <= 4'h0;
    end else if (ce) begin
      channelSel <= ctrl.channel;
      ccaDone <= 1'b0;
      if (!ccaBusy && ctrl.ccaStart) begin
        ccaBusy <= 1'b1;
        ccaCnt <= 13'h0000;
        ccaAcc <= 21'h000000;
      end else if (ccaBusy) begin
        ccaAcc <= ccaAccNext;
        ccaCnt <= ccaCnt + 13'h0001;
        if (ccaCnt == 13'(rpf_pkg::CCA_CYCLES - 1)) begin
          ccaBusy <= 1'b0;
          ccaLevel <= ccaAccNext[20:13];
          ccaDone <= 1'b1;
        end
      end
    end
  end

  // Host read-back and interrupt request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdPending <= 1'b0;
      hostRdData <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      rdPending <= hostRd && txState == TX_IDLE;
      if (streamTx && rxPayWr) begin
        hostRdData <= '{valid: 1'b1, data: rxSym.data};
      end else begin
        hostRdData <= '{valid: rdPending, data: ramRdData};
      end
      // Stream transmit asks for the next word whether or not the host has one ready
      irq <= (!streamTx && rxState == RX_FCS1 && rxSym.valid)
          || (streamTx && rxPayWr)
          || (!streamTx && txState == TX_FCS1 && txFire)
          || (streamTx && txState == TX_PAY && txWait);
    end
  end
endmodule

// file: rpf_framer_properties.sv
// Port-level assertions for the radio packet framer
`timescale 1ns/1ps
module rpf_framer_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire rpf_pkg::rpf_ctrl_t ctrl,
  input wire rpf_pkg::rpf_byte_t hostWr,
  input wire logic [6:0] hostAddr,
  input wire logic hostRd,
  input wire rpf_pkg::rpf_byte_t hostRdData,
  input wire rpf_pkg::rpf_byte_t rxSym,
  input wire logic rxPreambleSeen,
  input wire logic [7:0] energy,
  input wire logic modReady,
  input wire rpf_pkg::rpf_byte_t txSym,
  input wire rpf_pkg::rpf_stat_t stat,
  input wire logic [3:0] channelSel,
  input wire logic txUnderrun,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_chan;
    ce && $past(ce) && !$past(rst) |-> channelSel == $past(ctrl.channel);
  endproperty
  property p_txmod;
    txSym.valid |-> $past(modReady);
  endproperty
  property p_irq;
    irq |=> !irq;
  endproperty
  property p_cca;
    stat.ccaDone |=> !stat.ccaDone;
  endproperty
  property p_rd;
    hostRdData.valid && !ctrl.streamMode |-> $past(hostRd, 2);
  endproperty
  property p_len;
    stat.rxLen <= rpf_pkg::MAX_PAYLOAD_B;
  endproperty
  property p_srx;
    ctrl.streamMode && hostRdData.valid |-> (irq || $past(irq)) or ##1 irq;
  endproperty
  property p_crc;
    $changed(stat.crcOk) |-> $past(rxSym.valid) || $past(rxSym.valid, 2);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select does not follow request");
  a_txmod: assert property (p_txmod) else $error("byte sent without modulator ready");
  a_irq: assert property (p_irq) else $error("interrupt longer than one cycle");
  a_cca: assert property (p_cca) else $error("assessment done longer than one cycle");
  a_rd: assert property (p_rd) else $error("read data without read request");
  a_len: assert property (p_len) else $error("received length above maximum");
  a_srx: assert property (p_srx) else $error("streamed byte without interrupt");
  a_crc: assert property (p_crc) else $error("check result changed away from packet end");
  c_irq: cover property (irq);
  c_cca: cover property (stat.ccaDone);
  c_sfd: cover property (txSym.valid && txSym.data == rpf_pkg::SFD_BYTE);
endmodule
bind rpf_framer rpf_framer_properties chk_i (.mclk(mclk), .rst(rst), .ce(ce), .ctrl(ctrl),
  .hostWr(hostWr), .hostAddr(hostAddr), .hostRd(hostRd), .hostRdData(hostRdData),
  .rxSym(rxSym), .rxPreambleSeen(rxPreambleSeen), .energy(energy), .modReady(modReady),
  .txSym(txSym), .stat(stat), .channelSel(channelSel), .txUnderrun(txUnderrun), .irq(irq));

// file: rpf_mod_model.sv
// Modulator model: paces byte acceptance and records every byte sent
`timescale 1ns/1ps
module rpf_mod_model #(
  parameter int GAP = 0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire rpf_pkg::rpf_byte_t txSym,
  output logic modReady
);
  logic [7:0] got[$];
  int cnt;
  // Ready once every GAP+1 cycles, so the default GAP of 0 is ready on every cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      modReady <= 1'b0;
    end else begin
      cnt <= (cnt >= GAP) ? 0 : cnt + 1;
      modReady <= (cnt >= GAP);
    end
  end
  always @(posedge mclk) begin
    if (txSym.valid === 1'b1) got.push_back(txSym.data);
  end
endmodule

// file: rpf_pkg.sv
// Constants and carrier types for the radio packet framer
package rpf_pkg;
  localparam int MAX_PAYLOAD = 125;
  localparam logic [7:0] MAX_PAYLOAD_B = 8'h7D;
  localparam int PREAMBLE_LEN = 4;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0] SFD_BYTE = 8'hA7;
  localparam logic [15:0] FCS_INIT = 16'h0000;
  localparam logic [15:0] FCS_POLY_REV = 16'h8408;
  localparam int RAM_DEPTH = 128;
  localparam int RAM_AW = 7;
  localparam logic [6:0] LQI_ADDR = 7'h7F;
  localparam int CLK_MHZ = 50;
  localparam int LQ_WINDOW_US = 64;
  localparam int LQ_CYCLES = LQ_WINDOW_US * CLK_MHZ;
  localparam int CCA_WINDOW_US = 128;
  localparam int CCA_CYCLES = CCA_WINDOW_US * CLK_MHZ;
  localparam int NUM_CHANNELS = 16;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rpf_byte_t;
  typedef struct packed {
    logic streamMode;
    logic txStart;
    logic [7:0] txLen;
    logic rxEnable;
    logic ccaStart;
    logic [3:0] channel;
  } rpf_ctrl_t;
  typedef struct packed {
    logic crcOk;
    logic [7:0] rxLen;
    logic [7:0] ccaLevel;
    logic ccaDone;
  } rpf_stat_t;
endpackage

// file: rpf_ram.sv
// Packet buffer memory with registered read data
`timescale 1ns/1ps
module rpf_ram (
  input wire logic mclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [6:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic [6:0] rdAddr,
  output logic [7:0] rdData
);
  logic [7:0] mem [0:rpf_pkg::RAM_DEPTH-1];
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (we) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule
